// ### common/pcs_link_pkg.sv
`default_nettype none
package pcs_link_pkg;
  localparam int ADDR_W = 16;
  localparam logic [ADDR_W-1:0] LINK_CONTROL_ADDR = 16'h4208;
  localparam logic [ADDR_W-1:0] LINK_STATUS_ADDR = 16'h4300;
  localparam logic [ADDR_W-1:0] IRQ_STATUS_ADDR = 16'h4304;
  localparam logic [ADDR_W-1:0] IRQ_MASK_ADDR = 16'h4308;

  // link_control fields
  localparam int LINK_VALUE_BIT = 0;
  localparam int SPEED_VALUE_LSB = 1;
  localparam int DUPLEX_VALUE_BIT = 3;
  localparam int FORCE_SD_BIT = 4;
  localparam int FORCE_LINK_BIT = 5;
  localparam int LATCH_LOW_BIT = 6;
  localparam int AUTONEG_ENABLE_BIT = 16;
  localparam int AUTONEG_RESTART_BIT = 17;
  localparam int AN_TIMEOUT_BIT = 18;
  localparam int IDLE_SKIP_BIT = 19;
  localparam int AUTO_TRIG_BIT = 20;
  localparam int FAST_TIMER_BIT = 24;
  localparam int FIX_EN_BIT = 25;
  localparam logic [31:0] CTL_RESET = 32'h0204_000c;
  localparam logic [31:0] CTL_WMASK = 32'h031f_007f;
  localparam int NVM_AUTONEG_ENABLE_BIT = 11;

  // link_status fields
  localparam int ST_LINK_BIT = 0;
  localparam int ST_SPEED_LSB = 1;
  localparam int ST_DUPLEX_BIT = 3;
  localparam int ST_LATCHED_BIT = 4;
  localparam int ST_AUTONEG_ENABLE_BIT = 5;

  // irq_status / irq_mask fields
  localparam int IRQ_LINK_DOWN = 0;
  localparam int IRQ_LINK_UP = 1;
  localparam int IRQ_AN_START = 2;
  localparam int IRQ_W = 3;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned LINK_TIMER_NORMAL_NS = 10000000;
  localparam int unsigned LINK_TIMER_FAST_NS = 100000;
  localparam int unsigned LINK_TIMER_NORMAL_CYCLES = LINK_TIMER_NORMAL_NS / CLK_PERIOD_NS;
  localparam int unsigned LINK_TIMER_FAST_CYCLES = LINK_TIMER_FAST_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    SPEED_10 = 2'h0,
    SPEED_100 = 2'h1,
    SPEED_1000 = 2'h2,
    SPEED_RSVD = 2'h3
  } speed_t;

  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic rready;
  } axil_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axil_rsp_t;

  typedef struct packed {
    logic link_ok;
    logic [1:0] speed;
    logic duplex;
    logic sync_ok;
    logic phy_msg;
    logic serdes_mode;
  } sm_in_t;

  typedef struct packed {
    logic link_up;
    logic [1:0] speed;
    logic duplex;
  } link_out_t;

  typedef struct packed {
    logic autoneg_enable;
    logic an_start;
    logic autoneg_timeout_enable;
    logic sgmii_idle_skip;
    logic linkok_fix_enable;
    logic fast_link_timer;
  } an_ctl_t;

  typedef struct packed {
    logic [31:0] ctl;
    logic nvm_loaded;
    logic an_en_prev;
    logic aw_held;
    logic [ADDR_W-1:0] aw_addr;
    logic w_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    axil_rsp_t rsp;
    logic link_live;
    logic sync_prev;
    logic latched_low;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic irq;
    link_out_t link;
    an_ctl_t an;
    logic [31:0] timer;
  } state_t;
endpackage
`default_nettype wire

// ### design/pcs_link_control.sv
// Overview of operation
// R01: The forced duplex bit 3 resets to 1 and selects full duplex at 1, half duplex at 0, while forcing applies.
// R02: Forced speed and duplex also apply while autonegotiation is off or the port runs in SerDes mode.
// R03: With bit 4 set, speed and duplex follow the forced fields, else the negotiation machines.
// R04: With bit 5 set, the internal link-up follows bit 0, else the negotiation machines.
// R05: With bit 6 set, a link-up falling edge is reported as down until software reads the status.
// R06: Bit 16 enables autonegotiation; clearing it makes the forced speed and duplex apply.
// R07: Bit 16 takes its reset value from bit 11 of configuration word 0Fh.
// R08: Writing 1 to bit 17 restarts autonegotiation and the bit clears itself.
// R09: Bit 18, reset 1, lets negotiation declare link up on good idles without pages.
// R10: Software keeps bit 18 clear in SGMII mode.
// R11: Bit 19 makes SGMII negotiation skip the idle-detect state.
// R12: With bit 20 clear, SGMII sync loss does not start negotiation; only messages or bit changes do.
// R13: Bit 24 selects the short negotiation timer period instead of the normal one.
// R14: Bit 25, reset 1, turns the link-ok/sync-ok fix on or off.
// R15: Bit 0 means forced link down at 0 and forced link up at 1 while forcing is on.
// R16: Bits 2:1 reset to 10b and encode 10, 100 and 1000 Mb/s, with 11b reserved.
// R17: Reserved bits read zero and ignore writes, and the restart bit reads zero once taken.
//
// Decided for this implementation: the register addresses and register access over AXI4-Lite.
`default_nettype none
module pcs_link_control #(
  parameter int unsigned NORMAL_TIMER_CYCLES = pcs_link_pkg::LINK_TIMER_NORMAL_CYCLES,
  parameter int unsigned FAST_TIMER_CYCLES = pcs_link_pkg::LINK_TIMER_FAST_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire pcs_link_pkg::axil_req_t i_axi,
  output var pcs_link_pkg::axil_rsp_t o_axi,
  input wire pcs_link_pkg::sm_in_t i_sm,
  input wire logic [15:0] i_nvm_word_0f,
  output var pcs_link_pkg::link_out_t o_link,
  output var pcs_link_pkg::an_ctl_t o_an,
  output var logic [31:0] o_link_timer_cycles,
  output var logic o_irq
);

  pcs_link_pkg::state_t st;
  pcs_link_pkg::state_t next;

  function automatic logic [31:0] merge_strb(input logic [31:0] old, input logic [31:0] data,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = data[8*i +: 8];
      end
    end
    return res;
  endfunction

  logic force_sd;
  logic eff_link;
  logic link_fall;
  logic link_rise;
  logic sync_trig;
  logic en_rise;
  logic start_req;
  logic wr_go;
  logic rd_go;
  logic rd_status;
  logic rd_irq;
  logic [31:0] rd_word;
  logic rd_hit;
  logic [31:0] mask_merged;

  always_comb begin
    force_sd = st.ctl[pcs_link_pkg::FORCE_SD_BIT] || !st.ctl[pcs_link_pkg::AUTONEG_ENABLE_BIT] // R02 R03 R06
               || i_sm.serdes_mode;
    eff_link = st.ctl[pcs_link_pkg::FORCE_LINK_BIT] ? st.ctl[pcs_link_pkg::LINK_VALUE_BIT] : i_sm.link_ok; // R04 R15
    link_fall = st.link_live && !eff_link;
    link_rise = !st.link_live && eff_link;
    // SerDes always retriggers on sync loss; SGMII only when allowed
    sync_trig = st.sync_prev && !i_sm.sync_ok
                && (i_sm.serdes_mode || st.ctl[pcs_link_pkg::AUTO_TRIG_BIT]); // R12
    en_rise = st.ctl[pcs_link_pkg::AUTONEG_ENABLE_BIT] && !st.an_en_prev;
    start_req = st.ctl[pcs_link_pkg::AUTONEG_ENABLE_BIT]
                && (st.ctl[pcs_link_pkg::AUTONEG_RESTART_BIT] || i_sm.phy_msg || sync_trig || en_rise); // R08 R12
    wr_go = st.aw_held && st.w_held && !st.rsp.bvalid;
    rd_go = i_axi.arvalid && st.rsp.arready;
    rd_status = rd_go && i_axi.araddr == pcs_link_pkg::LINK_STATUS_ADDR;
    rd_irq = rd_go && i_axi.araddr == pcs_link_pkg::IRQ_STATUS_ADDR;
    // Widened so the byte-lane merge can be shared with the control register
    mask_merged = merge_strb({{(32-pcs_link_pkg::IRQ_W){1'b0}}, st.irq_mask}, st.wdata, st.wstrb);
  end

  always_comb begin
    rd_hit = 1'b1;
    rd_word = 32'h0000_0000;
    case (i_axi.araddr)
      pcs_link_pkg::LINK_CONTROL_ADDR: begin
        rd_word = st.ctl & pcs_link_pkg::CTL_WMASK; // R17
        rd_word[pcs_link_pkg::AUTONEG_RESTART_BIT] = 1'b0; // R17
      end
      pcs_link_pkg::LINK_STATUS_ADDR: begin
        rd_word[pcs_link_pkg::ST_LINK_BIT] = st.link.link_up;
        rd_word[pcs_link_pkg::ST_SPEED_LSB +: 2] = st.link.speed;
        rd_word[pcs_link_pkg::ST_DUPLEX_BIT] = st.link.duplex;
        rd_word[pcs_link_pkg::ST_LATCHED_BIT] = st.latched_low;
        rd_word[pcs_link_pkg::ST_AUTONEG_ENABLE_BIT] = st.an.autoneg_enable;
      end
      pcs_link_pkg::IRQ_STATUS_ADDR: begin
        rd_word[pcs_link_pkg::IRQ_W-1:0] = st.irq_stat;
      end
      pcs_link_pkg::IRQ_MASK_ADDR: begin
        rd_word[pcs_link_pkg::IRQ_W-1:0] = st.irq_mask;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  always_comb begin
    next = st;

    // Strap is sampled once after reset release, never under the reset itself
    if (!st.nvm_loaded) begin
      next.nvm_loaded = 1'b1;
      next.ctl[pcs_link_pkg::AUTONEG_ENABLE_BIT] = i_nvm_word_0f[pcs_link_pkg::NVM_AUTONEG_ENABLE_BIT]; // R07
    end

    // Restart lives one cycle: it becomes the start pulse and then drops
    next.ctl[pcs_link_pkg::AUTONEG_RESTART_BIT] = 1'b0; // R08 R17

    // Write channel
    if (i_axi.awvalid && st.rsp.awready) begin
      next.aw_held = 1'b1;
      next.aw_addr = i_axi.awaddr;
    end
    if (i_axi.wvalid && st.rsp.wready) begin
      next.w_held = 1'b1;
      next.wdata = i_axi.wdata;
      next.wstrb = i_axi.wstrb;
    end
    if (wr_go) begin
      next.aw_held = 1'b0;
      next.w_held = 1'b0;
      next.rsp.bvalid = 1'b1;
      next.rsp.bresp = pcs_link_pkg::RESP_OKAY;
      case (st.aw_addr)
        pcs_link_pkg::LINK_CONTROL_ADDR: begin
          next.ctl = merge_strb(next.ctl, st.wdata, st.wstrb) & pcs_link_pkg::CTL_WMASK; // R17
        end
        pcs_link_pkg::IRQ_MASK_ADDR: begin
          next.irq_mask = mask_merged[pcs_link_pkg::IRQ_W-1:0];
        end
        pcs_link_pkg::LINK_STATUS_ADDR, pcs_link_pkg::IRQ_STATUS_ADDR: begin
          next.rsp.bresp = pcs_link_pkg::RESP_OKAY;
        end
        default: begin
          next.rsp.bresp = pcs_link_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (st.rsp.bvalid && i_axi.bready) begin
      next.rsp.bvalid = 1'b0;
    end

    // Read channel
    if (st.rsp.rvalid && i_axi.rready) begin
      next.rsp.rvalid = 1'b0;
    end
    if (rd_go) begin
      next.rsp.rvalid = 1'b1;
      next.rsp.rdata = rd_word;
      next.rsp.rresp = rd_hit ? pcs_link_pkg::RESP_OKAY : pcs_link_pkg::RESP_SLVERR;
    end
    next.rsp.awready = !next.aw_held && !next.rsp.bvalid;
    next.rsp.wready = !next.w_held && !next.rsp.bvalid;
    next.rsp.arready = !next.rsp.rvalid;

    // Link reporting
    next.link_live = eff_link; // R04
    next.sync_prev = i_sm.sync_ok;
    next.an_en_prev = st.ctl[pcs_link_pkg::AUTONEG_ENABLE_BIT];
    if (rd_status) begin
      next.latched_low = 1'b0; // R05
    end
    if (link_fall && st.ctl[pcs_link_pkg::LATCH_LOW_BIT]) begin
      next.latched_low = 1'b1; // R05
    end
    next.link.link_up = eff_link && !next.latched_low; // R05
    next.link.speed = force_sd ? st.ctl[pcs_link_pkg::SPEED_VALUE_LSB +: 2] : i_sm.speed; // R03 R16
    next.link.duplex = force_sd ? st.ctl[pcs_link_pkg::DUPLEX_VALUE_BIT] : i_sm.duplex; // R01 R03

    // Negotiation controls
    next.an.autoneg_enable = st.ctl[pcs_link_pkg::AUTONEG_ENABLE_BIT]; // R06
    next.an.an_start = start_req; // R08 R12
    next.an.autoneg_timeout_enable = st.ctl[pcs_link_pkg::AN_TIMEOUT_BIT]; // R09
    next.an.sgmii_idle_skip = st.ctl[pcs_link_pkg::IDLE_SKIP_BIT]; // R11
    next.an.linkok_fix_enable = st.ctl[pcs_link_pkg::FIX_EN_BIT]; // R14
    next.an.fast_link_timer = st.ctl[pcs_link_pkg::FAST_TIMER_BIT]; // R13
    next.timer = st.ctl[pcs_link_pkg::FAST_TIMER_BIT] ? 32'(FAST_TIMER_CYCLES) : 32'(NORMAL_TIMER_CYCLES); // R13

    // Sticky events; a new event beats the read-clear
    if (rd_irq) begin
      next.irq_stat = '0;
    end
    next.irq_stat[pcs_link_pkg::IRQ_LINK_DOWN] = next.irq_stat[pcs_link_pkg::IRQ_LINK_DOWN] | link_fall;
    next.irq_stat[pcs_link_pkg::IRQ_LINK_UP] = next.irq_stat[pcs_link_pkg::IRQ_LINK_UP] | link_rise;
    next.irq_stat[pcs_link_pkg::IRQ_AN_START] = next.irq_stat[pcs_link_pkg::IRQ_AN_START] | start_req;
    next.irq = |(next.irq_stat & next.irq_mask);
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st <= '0;
      st.ctl <= pcs_link_pkg::CTL_RESET; // R01 R09 R14 R16
      st.link.speed <= pcs_link_pkg::SPEED_1000;
      st.link.duplex <= 1'b1;
      st.an.autoneg_timeout_enable <= 1'b1;
      st.an.linkok_fix_enable <= 1'b1;
      st.timer <= 32'(NORMAL_TIMER_CYCLES);
    end else begin
      st <= next;
    end
  end

  assign o_axi = st.rsp;
  assign o_link = st.link;
  assign o_an = st.an;
  assign o_link_timer_cycles = st.timer;
  assign o_irq = st.irq;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  a_forced_duplex: // R01
  assert property (st.ctl[pcs_link_pkg::FORCE_SD_BIT]
                   |=> st.link.duplex == $past(st.ctl[pcs_link_pkg::DUPLEX_VALUE_BIT]))
    else $error("forced duplex not applied");

  a_half_duplex: // R01
  assert property ((force_sd && !st.ctl[pcs_link_pkg::DUPLEX_VALUE_BIT]) |=> !st.link.duplex)
    else $error("forced half duplex not applied");

  a_an_off_forces: // R02
  assert property ((!st.ctl[pcs_link_pkg::AUTONEG_ENABLE_BIT] || i_sm.serdes_mode)
                   |=> st.link.speed == $past(st.ctl[pcs_link_pkg::SPEED_VALUE_LSB +: 2])
                       && st.link.duplex == $past(st.ctl[pcs_link_pkg::DUPLEX_VALUE_BIT]))
    else $error("forced values not used with negotiation off or serdes");

  a_sm_speed_follow: // R03
  assert property ((!st.ctl[pcs_link_pkg::FORCE_SD_BIT] && st.ctl[pcs_link_pkg::AUTONEG_ENABLE_BIT] && !i_sm.serdes_mode)
                   |=> st.link.speed == $past(i_sm.speed) && st.link.duplex == $past(i_sm.duplex))
    else $error("negotiated speed or duplex not followed");

  a_force_link_val: // R04
  assert property (st.ctl[pcs_link_pkg::FORCE_LINK_BIT]
                   |=> st.link_live == $past(st.ctl[pcs_link_pkg::LINK_VALUE_BIT]))
    else $error("forced link value not applied");

  a_link_follow: // R04
  assert property (!st.ctl[pcs_link_pkg::FORCE_LINK_BIT] |=> st.link_live == $past(i_sm.link_ok))
    else $error("negotiated link not followed");

  a_forced_link_down: // R15
  assert property ((st.ctl[pcs_link_pkg::FORCE_LINK_BIT] && !st.ctl[pcs_link_pkg::LINK_VALUE_BIT])
                   |=> !st.link.link_up)
    else $error("forced link down not reported");

  a_latch_released: // R05
  assert property ((st.latched_low && rd_status && !link_fall && eff_link) |=> st.link.link_up)
    else $error("link not reported up after status read");

  a_strap_load: // R07
  assert property (!st.nvm_loaded
                   |=> st.ctl[pcs_link_pkg::AUTONEG_ENABLE_BIT] == $past(i_nvm_word_0f[pcs_link_pkg::NVM_AUTONEG_ENABLE_BIT]))
    else $error("negotiation enable not loaded from strap");

  a_timeout_follow: // R09
  assert property (1'b1 |=> st.an.autoneg_timeout_enable == $past(st.ctl[pcs_link_pkg::AN_TIMEOUT_BIT]))
    else $error("timeout enable not passed on");

  a_idle_skip: // R11
  assert property (1'b1 |=> st.an.sgmii_idle_skip == $past(st.ctl[pcs_link_pkg::IDLE_SKIP_BIT]))
    else $error("idle skip not passed on");

  a_fix_follow: // R14
  assert property (1'b1 |=> st.an.linkok_fix_enable == $past(st.ctl[pcs_link_pkg::FIX_EN_BIT]))
    else $error("fix enable not passed on");

  a_sgmii_trig_on: // R12
  assert property ((st.sync_prev && !i_sm.sync_ok && st.ctl[pcs_link_pkg::AUTO_TRIG_BIT]
                    && st.ctl[pcs_link_pkg::AUTONEG_ENABLE_BIT]) |=> st.an.an_start)
    else $error("allowed sync loss did not start negotiation");

  a_normal_timer: // R13
  assert property (!st.ctl[pcs_link_pkg::FAST_TIMER_BIT] |=> o_link_timer_cycles == 32'(NORMAL_TIMER_CYCLES))
    else $error("normal timer period not selected");

  a_rsvd_ignored: // R17
  assert property ((st.ctl & ~pcs_link_pkg::CTL_WMASK) == 32'h0000_0000)
    else $error("reserved control bits held nonzero");

  a_irq_sticky: // R05
  assert property ((st.irq_stat[pcs_link_pkg::IRQ_LINK_DOWN] && !rd_irq)
                   |=> st.irq_stat[pcs_link_pkg::IRQ_LINK_DOWN])
    else $error("link down event lost before read");

  a_latch_holds_low: // R05
  assert property ((st.ctl[pcs_link_pkg::LATCH_LOW_BIT] && link_fall) ##1 (!rd_status)[*2] |=> !st.link.link_up)
    else $error("latched link down released without read");

  a_restart_pulse: // R08
  assert property ((st.ctl[pcs_link_pkg::AUTONEG_RESTART_BIT] && st.ctl[pcs_link_pkg::AUTONEG_ENABLE_BIT])
                   |=> st.an.an_start)
    else $error("restart did not start negotiation");

  a_restart_selfclr: // R17
  assert property ((st.ctl[pcs_link_pkg::AUTONEG_RESTART_BIT] && !wr_go) |=> !st.ctl[pcs_link_pkg::AUTONEG_RESTART_BIT])
    else $error("restart bit did not clear");

  a_no_sgmii_trig: // R12
  assert property ((st.sync_prev && !i_sm.sync_ok && !i_sm.serdes_mode && !st.ctl[pcs_link_pkg::AUTO_TRIG_BIT]
                    && !i_sm.phy_msg && !st.ctl[pcs_link_pkg::AUTONEG_RESTART_BIT] && !en_rise) |=> !st.an.an_start)
    else $error("sync loss started negotiation in sgmii");

  a_enable_starts: // R06
  assert property ($rose(st.ctl[pcs_link_pkg::AUTONEG_ENABLE_BIT]) |=> st.an.an_start && st.an.autoneg_enable)
    else $error("enable did not start negotiation");

  a_fast_timer: // R13
  assert property (st.ctl[pcs_link_pkg::FAST_TIMER_BIT] |=> o_link_timer_cycles == 32'(FAST_TIMER_CYCLES))
    else $error("fast timer period not selected");

  a_ctl_reserved_zero: // R17
  assert property ((rd_go && i_axi.araddr == pcs_link_pkg::LINK_CONTROL_ADDR)
                   |=> (st.rsp.rdata & ~pcs_link_pkg::CTL_WMASK) == 32'h0000_0000)
    else $error("reserved control bits read nonzero");

  a_irq_level: // R05
  assert property (|(st.irq_stat & st.irq_mask) |-> o_irq)
    else $error("interrupt not raised for pending event");

endmodule
`default_nettype wire

// ### bench/link_partner_model.sv
`default_nettype none
module link_partner_model #(
  parameter logic [1:0] PARTNER_SPEED = 2'h2,
  parameter logic PARTNER_DUPLEX = 1'b1
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_link,
  input wire logic i_sync,
  input wire logic i_serdes,
  input wire logic i_msg_req,
  output var pcs_link_pkg::sm_in_t o_sm
);
  timeunit 1ns;
  timeprecision 1ns;
  logic msg_prev;
  // One message pulse per request, however long the request stays up
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_sm <= '0;
      msg_prev <= 1'b0;
    end else begin
      msg_prev <= i_msg_req;
      o_sm.link_ok <= i_link;
      o_sm.speed <= PARTNER_SPEED;
      o_sm.duplex <= PARTNER_DUPLEX;
      o_sm.sync_ok <= i_sync;
      o_sm.serdes_mode <= i_serdes;
      o_sm.phy_msg <= i_msg_req && !msg_prev;
    end
  end
endmodule
`default_nettype wire

// ### bench/pcs_link_control_tb.sv
`default_nettype none
module pcs_link_control_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk;
  logic i_rst;
  pcs_link_pkg::axil_req_t req;
  pcs_link_pkg::axil_rsp_t rsp;
  pcs_link_pkg::sm_in_t sm;
  pcs_link_pkg::link_out_t lnk;
  pcs_link_pkg::an_ctl_t an;
  logic [31:0] tmr;
  logic irq;
  logic p_link, p_sync, p_serdes, p_msg;
  int error_cnt = 0;
  int checked = 0;
  int starts = 0;
  int s0;
  logic [31:0] d;
  logic [1:0] r;
  logic [31:0] tc[6] = '{32'h00010000, 32'h00010000, 32'h00000002, 32'h00010018, 32'h00010034, 32'h00010021};
  logic [5:0] tv[6] = '{6'h1d, 6'h38, 6'h1a, 6'h19, 6'h14, 6'h0d};

  pcs_link_control #(.NORMAL_TIMER_CYCLES(40), .FAST_TIMER_CYCLES(8)) pcs_link_control_inst (
    .i_clk(i_clk), .i_rst(i_rst), .i_axi(req), .o_axi(rsp), .i_sm(sm), .i_nvm_word_0f(16'h0800),
    .o_link(lnk), .o_an(an), .o_link_timer_cycles(tmr), .o_irq(irq));
  link_partner_model link_partner_model_inst (
    .i_clk(i_clk), .i_rst(i_rst), .i_link(p_link), .i_sync(p_sync), .i_serdes(p_serdes),
    .i_msg_req(p_msg), .o_sm(sm));

  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  always @(posedge i_clk) if (an.an_start === 1'b1) starts++;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic finish_test;
    $display("checked=%0d error_cnt=%0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Starts after an edge so a strobe dropped by the last call never gets set in the same step
  task automatic wr(input logic [15:0] a, input logic [31:0] v);
    int n;
    @(posedge i_clk);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= v;
    req.wstrb <= 4'hf;
    req.bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge i_clk);
      if (rsp.awready === 1'b1) req.awvalid <= 1'b0;
      if (rsp.wready === 1'b1) req.wvalid <= 1'b0;
      if (rsp.bvalid === 1'b1) break;
    end
    if (n == 50) error_cnt++;
    r = rsp.bresp;
    req.bready <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a);
    int n;
    @(posedge i_clk);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge i_clk);
      if (rsp.arready === 1'b1) req.arvalid <= 1'b0;
      if (rsp.rvalid === 1'b1) break;
    end
    if (n == 50) error_cnt++;
    d = rsp.rdata;
    r = rsp.rresp;
    req.rready <= 1'b0;
  endtask

  initial begin
    repeat (20000) @(posedge i_clk);
    error_cnt++;
    finish_test();
  end

  initial begin
    i_rst = 1'b1;
    req = '0;
    p_link = 1'b1;
    p_sync = 1'b1;
    p_serdes = 1'b1;
    p_msg = 1'b0;
    repeat (8) @(posedge i_clk);
    i_rst <= 1'b0;
    step(2);
    rd(pcs_link_pkg::LINK_CONTROL_ADDR);
    chk(d, 32'h0205000c);
    chk(tmr, 32'd40);
    wr(pcs_link_pkg::LINK_CONTROL_ADDR, 32'hffffffff);
    rd(pcs_link_pkg::LINK_CONTROL_ADDR);
    chk(d, 32'h031d007f);
    step(2);
    chk(tmr, 32'd8);
    wr(pcs_link_pkg::LINK_CONTROL_ADDR, 32'h02080000);
    step(3);
    chk(32'(an), 32'h06);
    wr(pcs_link_pkg::LINK_CONTROL_ADDR, 32'h01040000);
    step(3);
    chk(32'(an), 32'h09);
    rd(16'h4000);
    chk({d[29:0], r}, 32'h2);
    wr(16'h4000, 32'h1);
    chk(32'(r), 32'h2);
    for (int i = 0; i < 6; i++) begin
      p_serdes <= tv[i][5];
      p_link <= tv[i][4];
      wr(pcs_link_pkg::LINK_CONTROL_ADDR, tc[i]);
      step(3);
      chk(32'(lnk), 32'(tv[i][3:0]));
    end
    p_link <= 1'b1;
    wr(pcs_link_pkg::LINK_CONTROL_ADDR, 32'h00010040);
    step(3);
    rd(pcs_link_pkg::IRQ_STATUS_ADDR);
    wr(pcs_link_pkg::IRQ_MASK_ADDR, 32'h1);
    p_link <= 1'b0;
    step(3);
    p_link <= 1'b1;
    step(4);
    chk(32'(lnk.link_up), 32'h0);
    chk(32'(irq), 32'h1);
    rd(pcs_link_pkg::LINK_STATUS_ADDR);
    step(3);
    chk(32'(lnk.link_up), 32'h1);
    rd(pcs_link_pkg::IRQ_STATUS_ADDR);
    chk(d & 32'h1, 32'h1);
    step(2);
    chk(32'(irq), 32'h0);
    wr(pcs_link_pkg::LINK_CONTROL_ADDR, 32'h00010000);
    step(3);
    s0 = starts;
    p_sync <= 1'b0;
    step(4);
    chk(32'(starts - s0), 32'h0);
    p_sync <= 1'b1;
    wr(pcs_link_pkg::LINK_CONTROL_ADDR, 32'h00110000);
    step(3);
    s0 = starts;
    p_sync <= 1'b0;
    step(4);
    chk(32'(starts - s0), 32'h1);
    p_sync <= 1'b1;
    step(2);
    s0 = starts;
    p_msg <= 1'b1;
    step(4);
    p_msg <= 1'b0;
    chk(32'(starts - s0), 32'h1);
    s0 = starts;
    wr(pcs_link_pkg::LINK_CONTROL_ADDR, 32'h00030000);
    step(3);
    chk(32'(starts - s0), 32'h1);
    rd(pcs_link_pkg::LINK_CONTROL_ADDR);
    chk(d, 32'h00010000);
    finish_test();
  end
endmodule
`default_nettype wire
